// ===== shared/basr_pkg.sv
package basr_pkg;
  localparam int DATA_W = 16;
  localparam int CELLS = 12;
  localparam int ADDR_W = 8;
  localparam int READING_W = 12;
  // register offsets
  localparam logic [7:0] STATUS_OFFSET = 8'h02;
  localparam logic [7:0] CELL_FAULT_OFFSET = 8'h03;
  localparam logic [7:0] CELL_HIGH_OFFSET = 8'h04;
  localparam logic [7:0] CELL_LOW_OFFSET = 8'h05;
  // status word field positions
  localparam int RESET_SEEN_BIT = 15;
  localparam int OV_SUM_BIT = 14;
  localparam int UV_SUM_BIT = 13;
  localparam int SPREAD_BIT = 12;
  localparam int COLD_BIT = 11;
  localparam int HOT_BIT = 10;
  localparam int PEC_BIT = 9;
  localparam int NACK_BIT = 8;
  localparam int FAILURE_MODE_REGISTER_BIT = 7;
  localparam int AUX2_BIT = 1;
  localparam int AUX1_BIT = 0;
  // reset values
  localparam logic [15:0] STATUS_RESET = 16'h8000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // host walks through these
  typedef enum logic [1:0] {
    BASR_IDLE = 2'b00,
    BASR_WAIT = 2'b01,
    BASR_DONE = 2'b11
  } basr_host_state_type;
endpackage

// ===== shared/basr_if.sv
interface basr_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

// ===== logic/basr_cell_flags.sv
// per-cell high/low flags and their OR, one generate entry per cell
module basr_cell_flags
  import basr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic conv_done_i,
  input wire logic [basr_pkg::CELLS-1:0] cell_over_i,
  input wire logic [basr_pkg::CELLS-1:0] cell_under_i,
  output logic [basr_pkg::CELLS-1:0] high_o,
  output logic [basr_pkg::CELLS-1:0] low_o,
  output logic [basr_pkg::CELLS-1:0] fault_o
);
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      // flags follow the condition at each conversion
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          high_o[g] <= 1'b0;
          low_o[g] <= 1'b0;
        end else if (conv_done_i) begin
          high_o[g] <= cell_over_i[g]; // R22
          low_o[g] <= cell_under_i[g]; // R23
        end
      end
      assign fault_o[g] = high_o[g] | low_o[g]; // R20 R21
    end
  endgenerate
endmodule // basr_cell_flags

// ===== logic/basr_device.sv
// How it works
// (R1) power reset sets reset-seen flag D15
// (R2) writing 0 clears reset flag; 1 ignored
// (R3) host ignores packet errors while reset set
// (R4) D14 shows any cell overvoltage
// (R5) D13 shows any cell undervoltage
// (R6) D12 set when highest minus lowest exceeds threshold
// (R7) voltage flags clear at next clean conversion
// (R8) D11 cold when either aux above limit
// (R9) D10 hot when either aux below limit
// (R10) temperature flags clear at next clean conversion
// (R11) D9 set on packet check failure
// (R12) packet check is CRC-8 over message bytes
// (R13) packet flag sticks until 0 written
// (R14) D8 sticky unexpected NACK, cleared by 0
// (R15) D7 is OR of failure-mode bits
// (R16) D6..D2 read 0, writes ignored
// (R17) D1 second aux outside limits
// (R18) D0 first aux outside limits
// (R19) aux fault bits clear after clean measurement
// (R20) offset 0x03 holds per-cell OR, upper zero
// (R21) per-cell bits follow present fault state
// (R22) per-cell overvoltage register bits D0..D11
// (R23) per-cell undervoltage register bits D0..D11
// (R24) summaries are OR of per-cell flags
module basr_device
  import basr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  basr_if.dev bus,
  input wire logic conv_done_i,
  input wire logic [basr_pkg::CELLS-1:0] cell_over_i,
  input wire logic [basr_pkg::CELLS-1:0] cell_under_i,
  input wire logic [basr_pkg::READING_W-1:0] highest_cell_reading_i,
  input wire logic [basr_pkg::READING_W-1:0] lowest_cell_reading_i,
  input wire logic [basr_pkg::READING_W-1:0] spread_threshold_i,
  input wire logic [basr_pkg::READING_W-1:0] aux_input_first_i,
  input wire logic [basr_pkg::READING_W-1:0] aux_input_second_i,
  input wire logic [basr_pkg::READING_W-1:0] hot_limit_i,
  input wire logic [basr_pkg::READING_W-1:0] cold_limit_i,
  input wire logic packet_error_i, // R12 pulse from a failed CRC-8 byte check
  input wire logic nack_fault_i,
  input wire logic [basr_pkg::DATA_W-1:0] failure_mode_register_i,
  output logic status_alert_o
);
  import basr_pkg::*;

  logic reset_seen_flag;
  logic spread_flag;
  logic first_cold;
  logic first_hot;
  logic second_cold;
  logic second_hot;
  logic packet_error_flag;
  logic nack_fault_flag;
  logic failure_mode_summary_flag;
  logic ack;
  logic [DATA_W-1:0] rdata;
  logic status_alert;
  logic [CELLS-1:0] high_flags;
  logic [CELLS-1:0] low_flags;
  logic [CELLS-1:0] fault_flags;

  basr_cell_flags u_cells (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .conv_done_i(conv_done_i),
    .cell_over_i(cell_over_i),
    .cell_under_i(cell_under_i),
    .high_o(high_flags),
    .low_o(low_flags),
    .fault_o(fault_flags)
  );

  // address hits, one per mapped register
  wire hit_status = (bus.addr == STATUS_OFFSET);
  wire hit_cell_fault = (bus.addr == CELL_FAULT_OFFSET);
  wire hit_cell_high = (bus.addr == CELL_HIGH_OFFSET);
  wire hit_cell_low = (bus.addr == CELL_LOW_OFFSET);
  wire read_request = bus.req & ~bus.wr;

  // host write decode: only D15, D9 and D8 react, and only to a 0;
  // a 1 in any position leaves the flag alone so later events stay visible
  wire status_write = bus.req & bus.wr & hit_status;
  wire clear_reset = status_write & ~bus.wdata[RESET_SEEN_BIT]; // R2
  wire clear_pec = status_write & ~bus.wdata[PEC_BIT]; // R13
  wire clear_nack = status_write & ~bus.wdata[NACK_BIT]; // R14

  // cell spread test; the ordering term keeps a wrapped difference from
  // setting the flag when a stale lowest reading sits above the highest one
  wire spread_ordered = (highest_cell_reading_i > lowest_cell_reading_i);
  wire [READING_W-1:0] spread_value = highest_cell_reading_i - lowest_cell_reading_i;
  wire spread_now = spread_ordered & (spread_value > spread_threshold_i); // R6

  // aux comparisons; a high reading means cold with a falling-resistance sensor
  wire first_cold_now = (aux_input_first_i > cold_limit_i); // R8
  wire first_hot_now = (aux_input_first_i < hot_limit_i); // R9
  wire second_cold_now = (aux_input_second_i > cold_limit_i); // R8
  wire second_hot_now = (aux_input_second_i < hot_limit_i); // R9

  // summaries, recomputed every cycle from the held per-cell and aux flags
  wire overvoltage_summary_flag = |high_flags; // R4 R24
  wire undervoltage_summary_flag = |low_flags; // R5 R24
  wire cold_temperature_flag = first_cold | second_cold; // R8
  wire hot_temperature_flag = first_hot | second_hot; // R9
  wire second_aux_fault_flag = second_cold | second_hot; // R17
  wire first_aux_fault_flag = first_cold | first_hot; // R18

  // assembled status word, each field at its package position
  wire [DATA_W-1:0] status_word;
  assign status_word[RESET_SEEN_BIT] = reset_seen_flag; // R1
  assign status_word[OV_SUM_BIT] = overvoltage_summary_flag; // R4
  assign status_word[UV_SUM_BIT] = undervoltage_summary_flag; // R5
  assign status_word[SPREAD_BIT] = spread_flag; // R6
  assign status_word[COLD_BIT] = cold_temperature_flag; // R8
  assign status_word[HOT_BIT] = hot_temperature_flag; // R9
  assign status_word[PEC_BIT] = packet_error_flag; // R11
  assign status_word[NACK_BIT] = nack_fault_flag; // R14
  assign status_word[FAILURE_MODE_REGISTER_BIT] = failure_mode_summary_flag; // R15
  assign status_word[FAILURE_MODE_REGISTER_BIT-1:AUX2_BIT+1] = 5'b0_0000; // R16
  assign status_word[AUX2_BIT] = second_aux_fault_flag; // R17
  assign status_word[AUX1_BIT] = first_aux_fault_flag; // R18

  // per-cell words, upper four bits always read 0
  wire [DATA_W-1:0] cell_word = {4'h0, fault_flags}; // R20
  wire [DATA_W-1:0] high_word = {4'h0, high_flags}; // R22
  wire [DATA_W-1:0] low_word = {4'h0, low_flags}; // R23

  // read select; unmapped offsets read 0, and writes leave rdata at 0
  wire [DATA_W-1:0] read_mux =
    hit_status ? status_word :
    hit_cell_fault ? cell_word :
    hit_cell_high ? high_word :
    hit_cell_low ? low_word : ZERO_WORD;
  wire [DATA_W-1:0] next_rdata = read_request ? read_mux : ZERO_WORD;

  // alert line: any of D15..D7, kept quiet until the host has cleared
  // the reset flag, because a fresh power-up reads with that flag high
  wire next_alert = (|status_word[DATA_W-1:FAILURE_MODE_REGISTER_BIT]) & ~reset_seen_flag;

  // reset-seen flag: only a reset sets it, only a written 0 clears it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reset_seen_flag <= 1'b1; // R1
    end else if (clear_reset) begin
      reset_seen_flag <= 1'b0; // R2
    end
  end

  // packet-error flag: an event in the clearing cycle wins over the clear,
  // so no failure is lost while the host clears an older one
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      packet_error_flag <= 1'b0;
    end else begin
      packet_error_flag <= packet_error_i | (packet_error_flag & ~clear_pec); // R11 R13
    end
  end

  // nack-fault flag: same set-wins rule as the packet-error flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nack_fault_flag <= 1'b0;
    end else begin
      nack_fault_flag <= nack_fault_i | (nack_fault_flag & ~clear_nack); // R14
    end
  end

  // conversion-driven flags, refreshed only at a conversion; between
  // conversions they hold, even if the inputs move
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      spread_flag <= 1'b0;
      first_cold <= 1'b0;
      first_hot <= 1'b0;
      second_cold <= 1'b0;
      second_hot <= 1'b0;
    end else if (conv_done_i) begin
      spread_flag <= spread_now; // R7
      first_cold <= first_cold_now; // R10 R19
      first_hot <= first_hot_now; // R10 R19
      second_cold <= second_cold_now; // R10 R19
      second_hot <= second_hot_now; // R10 R19
    end
  end

  // failure-mode summary, one register stage behind its source
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) failure_mode_summary_flag <= 1'b0;
    else failure_mode_summary_flag <= |failure_mode_register_i; // R15
  end

  // register bus answer, one cycle after request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= ZERO_WORD;
    end else begin
      ack <= bus.req;
      rdata <= next_rdata;
    end
  end

  // alert output, registered so the pin never glitches
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_alert <= 1'b0;
    end else begin
      status_alert <= next_alert;
    end
  end

  // outputs straight from their flip-flops

  assign bus.ack = ack;
  assign bus.rdata = rdata;
  assign status_alert_o = status_alert;
endmodule // basr_device

// ===== logic/basr_host.sv
// host end: one register read or write per command
module basr_host
  import basr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  basr_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [basr_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [basr_pkg::DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [basr_pkg::DATA_W-1:0] rdata_o,
  output logic pec_error_valid_o
);
  import basr_pkg::*;

  basr_host_state_type state;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  logic reset_seen_copy;
  logic pec_valid;

  wire start = (state == BASR_IDLE) & cmd_valid_i;
  wire status_read = ~wr & (addr == STATUS_OFFSET);

  // command sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= BASR_IDLE;
      req <= 1'b0;
      wr <= 1'b0;
      addr <= 8'h00;
      wdata <= ZERO_WORD;
      done <= 1'b0;
      rdata <= ZERO_WORD;
    end else begin
      done <= 1'b0;
      case (state)
        BASR_IDLE: begin
          if (start) begin
            req <= 1'b1;
            wr <= cmd_write_i;
            addr <= cmd_addr_i;
            wdata <= cmd_wdata_i; // R2 R13 R14
            state <= BASR_WAIT;
          end
        end
        BASR_WAIT: begin
          req <= 1'b0;
          if (bus.ack) begin
            rdata <= bus.rdata;
            done <= 1'b1;
            state <= BASR_DONE;
          end
        end
        default: begin
          state <= BASR_IDLE;
        end
      endcase
    end
  end

  // packet errors count only once the reset flag was seen clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reset_seen_copy <= 1'b1;
      pec_valid <= 1'b0;
    end else if ((state == BASR_WAIT) & bus.ack & status_read) begin
      reset_seen_copy <= bus.rdata[RESET_SEEN_BIT];
      pec_valid <= bus.rdata[PEC_BIT] & ~bus.rdata[RESET_SEEN_BIT]; // R3
    end
  end

  assign bus.req = req;
  assign bus.wr = wr;
  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign cmd_ready_o = (state == BASR_IDLE);
  assign done_o = done;
  assign rdata_o = rdata;
  assign pec_error_valid_o = pec_valid;
endmodule // basr_host

// ===== dv/basr_sva.sv
// protocol and register-shape checks on the link between host and device
module basr_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic cleared;
  // remembers a host write of 0 to the reset-seen flag since reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) cleared <= 1'b0;
    else if (req && wr && addr == 8'h02 && !wdata[15]) cleared <= 1'b1;
  end
  property p_ack;
    req |=> ack ##1 !ack;
  endproperty
  property p_rst_set;
    ack && !$past(wr) && $past(addr) == 8'h02 && !cleared |-> rdata[15];
  endproperty
  property p_rst_clr;
    ack && !$past(wr) && $past(addr) == 8'h02 && cleared |-> !rdata[15];
  endproperty
  property p_rsvd;
    ack && $past(addr) == 8'h02 |-> rdata[6:2] == 5'h0;
  endproperty
  property p_cell;
    ack && $past(addr) == 8'h03 |-> rdata[15:12] == 4'h0;
  endproperty
  property p_high;
    ack && $past(addr) == 8'h04 |-> rdata[15:12] == 4'h0;
  endproperty
  property p_low;
    ack && $past(addr) == 8'h05 |-> rdata[15:12] == 4'h0;
  endproperty
  property p_unmap;
    ack && ($past(addr) < 8'h02 || $past(addr) > 8'h05) |-> rdata == 16'h0000;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after req");
  a_rst_set: assert property (p_rst_set) else $error("reset flag missing");
  a_rst_clr: assert property (p_rst_clr) else $error("reset flag not cleared");
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  a_cell: assert property (p_cell) else $error("cell fault upper bits set");
  a_high: assert property (p_high) else $error("cell high upper bits set");
  a_low: assert property (p_low) else $error("cell low upper bits set");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // main traffic kinds
  c_status: cover property (ack && !$past(wr) && $past(addr) == 8'h02);
  c_write: cover property (ack && $past(wr));
  c_cell: cover property (ack && $past(addr) == 8'h03 && rdata != 16'h0000);
endmodule // basr_sva

// ===== dv/tb_top.sv
// host end and device end joined back to back, driven through host commands
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import basr_pkg::*;
  logic ref_clk_i, rst_i, cv, cw, rdy, done, pev, alert;
  logic [2:0] ev;
  logic [7:0] ca;
  logic [15:0] cd, rd, q, fmr;
  logic [11:0] ov, uv, hi, lo, thr, a1, a2, hot, cold;
  int n_errors, checks;
  basr_if bus();
  basr_device u_basr_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus),
    .conv_done_i(ev[2]), .cell_over_i(ov), .cell_under_i(uv),
    .highest_cell_reading_i(hi), .lowest_cell_reading_i(lo), .spread_threshold_i(thr),
    .aux_input_first_i(a1), .aux_input_second_i(a2), .hot_limit_i(hot),
    .cold_limit_i(cold), .packet_error_i(ev[1]), .nack_fault_i(ev[0]),
    .failure_mode_register_i(fmr), .status_alert_o(alert));
  basr_host u_basr_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus),
    .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
    .cmd_ready_o(rdy), .done_o(done), .rdata_o(rd), .pec_error_valid_o(pev));
  basr_sva u_basr_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req(bus.req), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata));
  // 200 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude;
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one host command, held until taken, then wait for done
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1) begin @(posedge ref_clk_i); #1; end
    cv = 1'b1; cw = w; ca = a; cd = d;
    @(posedge ref_clk_i); #1;
    cv = 1'b0;
    while (done !== 1'b1 && n < 20) begin @(posedge ref_clk_i); #1; n++; end
    if (n == 20) chk(16'h0001, 16'h0000);
    q = rd;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk(q, exp);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  // one-cycle event pulse: conversion, packet error, nack
  task automatic pulse(input logic [2:0] e);
    ev = e;
    @(posedge ref_clk_i); #1;
    ev = 3'h0;
  endtask
  // hang guard
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
  // test sequence
  initial begin
    rst_i = 1'b1; cv = 1'b0; cw = 1'b0; ca = 8'h00; cd = 16'h0000; ev = 3'h0;
    ov = 12'h000; uv = 12'h000; fmr = 16'h0000; hi = 12'h000; lo = 12'h000;
    thr = 12'hfff; a1 = 12'h800; a2 = 12'h800; hot = 12'h200; cold = 12'hc00;
    n_errors = 0; checks = 0;
    repeat (8) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    rdc(8'h02, 16'h8000);
    wrr(8'h02, 16'hffff); rdc(8'h02, 16'h8000);
    wrr(8'h02, 16'h0000); rdc(8'h02, 16'h0000);
    rdc(8'h10, 16'h0000);
    ov = 12'h801; uv = 12'h002; pulse(3'h4);
    wrr(8'h03, 16'hffff); rdc(8'h03, 16'h0803);
    rdc(8'h04, 16'h0801);
    rdc(8'h05, 16'h0002);
    ov = 12'h000; uv = 12'h000; rdc(8'h02, 16'h6000);
    pulse(3'h4); rdc(8'h03, 16'h0000);
    rdc(8'h02, 16'h0000);
    hi = 12'h800; lo = 12'h100; thr = 12'h6ff; a1 = 12'h100; a2 = 12'hd00; fmr = 16'h0010;
    pulse(3'h4); wrr(8'h02, 16'hffff); rdc(8'h02, 16'h1c83);
    thr = 12'h700; a1 = 12'h800; a2 = 12'h800; fmr = 16'h0000;
    pulse(3'h4); rdc(8'h02, 16'h0000);
    pulse(3'h3); wrr(8'h02, 16'hffff); rdc(8'h02, 16'h0300);
    chk({14'h0, pev, alert}, 16'h0003);
    wrr(8'h02, 16'h0000); rdc(8'h02, 16'h0000);
    conclude;
  end
endmodule // tb_top
